// ---- rctwa_pkg.sv ----
// constants and carriers for the calendar, rate trim and weekly alarm
// ----
// Function
// R1: day counts 1..31 in months 1,3,5,7,8,10,12, 1..30 in 4,6,9,11
// R2: february ends at 29 in leap years, 28 otherwise
// R3: day wrap from last day to 1 increments month
// R4: month counts 1..12 in BCD, wrap 12 to 1 increments year
// R5: year counts 00..99 BCD, every year divisible by four is leap
// R6: century bit toggles when year wraps 99 to 00
// R7: host writes only existing dates, bad carries may misbehave
// R8: day register at 4h, tens bits 5-4, units 3-0, 7-6 read zero
// R9: month register at 5h, century bit 7, tens bit 4, units 3-0
// R10: year register at 6h, two full BCD digits, all bits read/write
// R11: trim write takes effect only with guard bit 7 at zero
// R12: halt flag setting clears whole trim register
// R13: second is 32768 crystal cycles, adjusted only at 00, 20, 40
// R14: writing trim arms it, never applied at the boundary of the write
// R15: sign 0 lengthens second by (field minus one) times two
// R16: sign 1 shortens second by (inverted field plus one) times two
// R17: field bits 5..1 all zero means no adjustment
// R18: alarm minute at 8h, tens bits 6-4, units 3-0, bit 7 zero
// R19: alarm hour at 9h, bit 5 pm/20, bit 4 tens, units 3-0
// R20: halt flag sets when crystal stops, stays until host clears
// R21: alarm hour bit 5 is pm in 12h mode, tens-of-twenty in 24h
// R22: correction changes only that one second's terminal count
// R23: calendar and alarm values need not clear on halt
// ----
package rctwa_pkg;
	// ----
	// register offsets
	// ----
	localparam logic [3:0] ADDR_DAY   = 4'h4;
	localparam logic [3:0] ADDR_MONTH = 4'h5;
	localparam logic [3:0] ADDR_YEAR  = 4'h6;
	localparam logic [3:0] ADDR_TRIM  = 4'h7;
	localparam logic [3:0] ADDR_WMIN  = 4'h8;
	localparam logic [3:0] ADDR_WHOUR = 4'h9;
	// ----
	// field positions
	// ----
	localparam int CENT_BIT  = 7;
	localparam int GUARD_BIT = 7;
	localparam int SIGN_BIT  = 6;
	// ----
	// reset values
	// ----
	localparam logic [5:0] DAY_RST   = 6'h01;
	localparam logic [4:0] MONTH_RST = 5'h01;
	localparam logic [7:0] YEAR_RST  = 8'h00;
	localparam logic [6:0] TRIM_RST  = 7'h00;
	localparam logic [6:0] WMIN_RST  = 7'h00;
	localparam logic [5:0] WHOUR_RST = 6'h00;
	// ----
	// timing
	// ----
	localparam logic [15:0] SEC_COUNT  = 16'h8000;
	localparam logic [4:0]  TRIM_SECS  = 5'h14;
	localparam int          CLK_MHZ    = 100;
	localparam int          HALT_US    = 100;
	localparam int          HALT_CYCLES = HALT_US * CLK_MHZ;
	// ----
	// carriers
	// ----
	typedef struct packed {
		logic       cent;
		logic [4:0] month;
		logic [7:0] year;
		logic [5:0] day;
	} rctwa_cal_t;
	typedef struct packed {
		logic [6:0] minute;
		logic [5:0] hour;
	} rctwa_alarm_t;
endpackage

// ---- rctwa_core.sv ----
// calendar counters, rate-trimmed crystal divider and weekly alarm regs
`timescale 1ns/10ps
module rctwa_core #(
	parameter int HALT_CYCLES = rctwa_pkg::HALT_CYCLES
) (
	input  wire logic                    clk,          // system clock
	input  wire logic                    resetn,       // async, low
	input  wire logic                    xtal_clk,     // crystal clock
	input  wire logic                    reg_wr,       // write strobe
	input  wire logic                    reg_rd,       // read strobe
	input  wire logic [3:0]              reg_addr,     // register addr
	input  wire logic [7:0]              reg_wdata,    // write data
	output logic [7:0]                   reg_rdata,    // read data
	input  wire logic                    day_carry,    // hour wrap pulse
	input  wire logic                    osc_halt_clr, // clear halt
	output logic                         sec_pulse,    // one per second
	output logic                         osc_halt_flag, // halt seen
	output rctwa_pkg::rctwa_cal_t        cal,          // calendar
	output rctwa_pkg::rctwa_alarm_t      walarm        // weekly alarm
);
	// ----
	// parameter check
	// ----
	localparam int HW = $clog2(HALT_CYCLES + 1);
	generate
		if (HALT_CYCLES < 4) begin : g_bad
			$error("HALT_CYCLES too small");
		end
	endgenerate

	// ----
	// reset release
	// ----
	logic rs1_r;
	logic rst_n;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rs1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs1_r <= 1'b1;
			rst_n <= rs1_r;
		end
	end

	logic xr1_r;
	logic xrst_n;
	always_ff @(posedge xtal_clk or negedge resetn) begin
		if (!resetn) begin
			xr1_r  <= 1'b0;
			xrst_n <= 1'b0;
		end else begin
			xr1_r  <= 1'b1;
			xrst_n <= xr1_r;
		end
	end

	// ----
	// register decode
	// ----
	wire wr_day   = reg_wr && reg_addr == rctwa_pkg::ADDR_DAY;
	wire wr_month = reg_wr && reg_addr == rctwa_pkg::ADDR_MONTH;
	wire wr_year  = reg_wr && reg_addr == rctwa_pkg::ADDR_YEAR;
	wire wr_trim  = reg_wr && reg_addr == rctwa_pkg::ADDR_TRIM;
	wire wr_wmin  = reg_wr && reg_addr == rctwa_pkg::ADDR_WMIN;
	wire wr_whour = reg_wr && reg_addr == rctwa_pkg::ADDR_WHOUR;
	// a write with the guard bit set is dropped entirely
	wire trim_ok  = wr_trim && !reg_wdata[rctwa_pkg::GUARD_BIT]; // R11

	// ----
	// calendar arithmetic
	// ----
	rctwa_pkg::rctwa_cal_t cal_r;
	rctwa_pkg::rctwa_cal_t cal_nxt;

	wire [3:0] yu = cal_r.year[3:0];
	// BCD year divisible by four: even tens with 0/4/8, odd with 2/6
	wire leap = cal_r.year[4] ? (yu == 4'h2 || yu == 4'h6) // R5
	                          : (yu == 4'h0 || yu == 4'h4 || yu == 4'h8);

	wire m30 = cal_r.month == 5'h04 || cal_r.month == 5'h06 ||
	           cal_r.month == 5'h09 || cal_r.month == 5'h11;
	wire feb = cal_r.month == 5'h02;
	wire [5:0] last_day = feb ? (leap ? 6'h29 : 6'h28) : // R2
	                      m30 ? 6'h30 : 6'h31; // R1

	wire day_end  = cal_r.day == last_day;
	wire day_wrap = day_carry && day_end; // R3
	wire mon_wrap = day_wrap && cal_r.month == 5'h12; // R4
	wire yr_wrap  = mon_wrap && cal_r.year == 8'h99; // R6

	wire [1:0] dt1 = cal_r.day[5:4] + 2'h1;
	wire [3:0] du1 = cal_r.day[3:0] + 4'h1;
	wire [5:0] day_inc = day_end ? 6'h01 : // R1
	                     cal_r.day[3:0] == 4'h9 ? {dt1, 4'h0} :
	                     {cal_r.day[5:4], du1};

	wire [3:0] mu1 = cal_r.month[3:0] + 4'h1;
	wire [4:0] mon_inc = cal_r.month == 5'h12 ? 5'h01 : // R4
	                     cal_r.month == 5'h09 ? 5'h10 :
	                     {cal_r.month[4], mu1};

	wire [3:0] yt1 = cal_r.year[7:4] + 4'h1;
	wire [3:0] yu1 = yu + 4'h1;
	wire [7:0] year_inc = cal_r.year == 8'h99 ? 8'h00 : // R5
	                      yu == 4'h9 ? {yt1, 4'h0} :
	                      {cal_r.year[7:4], yu1};

	// a host write wins over a carry landing in the same cycle
	always_comb begin
		cal_nxt = cal_r;
		if (wr_day) begin
			cal_nxt.day = reg_wdata[5:0]; // R8
		end else if (day_carry) begin
			cal_nxt.day = day_inc;
		end
		if (wr_month) begin
			cal_nxt.month = reg_wdata[4:0]; // R9
			cal_nxt.cent  = reg_wdata[rctwa_pkg::CENT_BIT];
		end else if (day_wrap) begin
			cal_nxt.month = mon_inc; // R3
			if (yr_wrap) begin
				cal_nxt.cent = ~cal_r.cent; // R6
			end
		end
		if (wr_year) begin
			cal_nxt.year = reg_wdata; // R10
		end else if (mon_wrap) begin
			cal_nxt.year = year_inc; // R4
		end
	end

	// calendar and alarm survive a halt untouched
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cal_r.day   <= rctwa_pkg::DAY_RST;
			cal_r.month <= rctwa_pkg::MONTH_RST;
			cal_r.year  <= rctwa_pkg::YEAR_RST;
			cal_r.cent  <= 1'b0;
		end else begin
			cal_r <= cal_nxt; // R23
		end
	end

	// ----
	// weekly alarm registers
	// ----
	rctwa_pkg::rctwa_alarm_t wal_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wal_r.minute <= rctwa_pkg::WMIN_RST;
			wal_r.hour   <= rctwa_pkg::WHOUR_RST;
		end else begin
			if (wr_wmin) begin
				wal_r.minute <= reg_wdata[6:0]; // R18
			end
			// bit 5 kept raw: its meaning follows the hour mode
			if (wr_whour) begin
				wal_r.hour <= reg_wdata[5:0]; // R19 R21
			end
		end
	end

	// ----
	// oscillator halt watch
	// ----
	// the crystal side toggles a heartbeat; silence means a stop
	logic hb1_r;
	logic hb2_r;
	logic hb3_r;
	logic [HW-1:0] quiet_r;
	logic halt_r;
	logic hb_x_r;

	wire hb_seen  = hb2_r ^ hb3_r;
	wire halt_det = quiet_r == HW'(HALT_CYCLES);
	wire halt_set = halt_det && !halt_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hb1_r <= 1'b0;
			hb2_r <= 1'b0;
			hb3_r <= 1'b0;
		end else begin
			hb1_r <= hb_x_r;
			hb2_r <= hb1_r;
			hb3_r <= hb2_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			quiet_r <= '0;
		end else if (hb_seen) begin
			quiet_r <= '0;
		end else if (!halt_det) begin
			quiet_r <= quiet_r + HW'(1);
		end
	end

	// flag powers up set; a stop seen while clearing keeps it set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			halt_r <= 1'b1;
		end else if (halt_det) begin
			halt_r <= 1'b1; // R20
		end else if (osc_halt_clr) begin
			halt_r <= 1'b0;
		end
	end

	// ----
	// trim register and its crossing
	// ----
	logic [6:0] trim_r;
	logic       trim_tg_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trim_r    <= rctwa_pkg::TRIM_RST;
			trim_tg_r <= 1'b0;
		end else if (halt_set) begin
			trim_r    <= rctwa_pkg::TRIM_RST; // R12
			trim_tg_r <= ~trim_tg_r;
		end else if (trim_ok) begin
			trim_r    <= reg_wdata[6:0]; // R11
			trim_tg_r <= ~trim_tg_r;
		end
	end

	// ----
	// crystal domain divider
	// ----
	logic        tg1_r;
	logic        tg2_r;
	logic        tg3_r;
	logic [6:0]  trim_x_r;
	logic        armed_r;
	logic [15:0] div_r;
	logic [15:0] term_r;
	logic [4:0]  phase_r;
	logic        sec_tg_r;

	// trim_r is stable for many crystal cycles when the toggle lands
	wire take_trim = tg2_r ^ tg3_r;
	wire [5:0] fld = trim_x_r[5:0];
	wire       sgn = trim_x_r[rctwa_pkg::SIGN_BIT];
	wire adj_on = |fld[5:1]; // R17
	wire [15:0] up_amt = {9'h000, fld, 1'b0} - 16'h0002; // R15
	wire [15:0] dn_amt = {9'h000, ~fld, 1'b0} + 16'h0002; // R16
	wire [15:0] adj_term = sgn ? rctwa_pkg::SEC_COUNT - dn_amt
	                           : rctwa_pkg::SEC_COUNT + up_amt;
	wire sec_end = div_r == term_r - 16'h0001;
	wire [4:0] phase_inc = phase_r + 5'h01;
	wire [4:0] phase_nxt = phase_inc == rctwa_pkg::TRIM_SECS ? 5'h00
	                                                          : phase_inc;
	// only the second that opens each twenty-second group is trimmed
	wire use_adj = phase_nxt == 5'h00 && armed_r && adj_on; // R13
	wire [15:0] term_nxt = use_adj ? adj_term
	                               : rctwa_pkg::SEC_COUNT; // R22

	always_ff @(posedge xtal_clk or negedge xrst_n) begin
		if (!xrst_n) begin
			tg1_r <= 1'b0;
			tg2_r <= 1'b0;
			tg3_r <= 1'b0;
			hb_x_r <= 1'b0;
		end else begin
			tg1_r <= trim_tg_r;
			tg2_r <= tg1_r;
			tg3_r <= tg2_r;
			hb_x_r <= ~hb_x_r;
		end
	end

	// a capture on the boundary edge lands after term_nxt was taken
	always_ff @(posedge xtal_clk or negedge xrst_n) begin
		if (!xrst_n) begin
			trim_x_r <= rctwa_pkg::TRIM_RST;
			armed_r  <= 1'b0;
		end else if (take_trim) begin
			trim_x_r <= trim_r; // R14
			armed_r  <= 1'b1; // R14
		end
	end

	always_ff @(posedge xtal_clk or negedge xrst_n) begin
		if (!xrst_n) begin
			div_r    <= 16'h0000;
			term_r   <= rctwa_pkg::SEC_COUNT;
			phase_r  <= 5'h00;
			sec_tg_r <= 1'b0;
		end else if (sec_end) begin
			div_r    <= 16'h0000;
			term_r   <= term_nxt; // R22
			phase_r  <= phase_nxt; // R13
			sec_tg_r <= ~sec_tg_r;
		end else begin
			div_r <= div_r + 16'h0001; // R13
		end
	end

	// ----
	// second tick back to clk
	// ----
	logic ss1_r;
	logic ss2_r;
	logic ss3_r;
	logic sec_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ss1_r <= 1'b0;
			ss2_r <= 1'b0;
			ss3_r <= 1'b0;
			sec_r <= 1'b0;
		end else begin
			ss1_r <= sec_tg_r;
			ss2_r <= ss1_r;
			ss3_r <= ss2_r;
			sec_r <= ss2_r ^ ss3_r;
		end
	end

	// ----
	// read back
	// ----
	logic [7:0] rdata_r;
	wire [7:0] rd_mux =
		reg_addr == rctwa_pkg::ADDR_DAY   ? {2'h0, cal_r.day} : // R8
		reg_addr == rctwa_pkg::ADDR_MONTH ?
			{cal_r.cent, 2'h0, cal_r.month} : // R9
		reg_addr == rctwa_pkg::ADDR_YEAR  ? cal_r.year : // R10
		reg_addr == rctwa_pkg::ADDR_TRIM  ? {1'b0, trim_r} :
		reg_addr == rctwa_pkg::ADDR_WMIN  ? {1'b0, wal_r.minute} : // R18
		reg_addr == rctwa_pkg::ADDR_WHOUR ? {2'h0, wal_r.hour} : // R19
		8'h00;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			rdata_r <= rd_mux;
		end
	end

	// ----
	// outputs
	// ----
	assign reg_rdata     = rdata_r;
	assign sec_pulse     = sec_r;
	assign osc_halt_flag = halt_r;
	assign cal           = cal_r;
	assign walarm        = wal_r;
endmodule // rctwa_core

// ---- rctwa_chk_checker.sv ----
// assertions on the calendar and register port of the core
`timescale 1ns/10ps
module rctwa_chk (
	input wire logic                  clk,       // system clock
	input wire logic                  resetn,    // async, low
	input wire logic                  reg_wr,    // write strobe
	input wire logic                  reg_rd,    // read strobe
	input wire logic [3:0]            reg_addr,  // register addr
	input wire logic [7:0]            reg_wdata, // write data
	input wire logic [7:0]            reg_rdata, // read data
	input wire logic                  osc_halt_clr,  // clear halt
	input wire logic                  osc_halt_flag, // halt seen
	input wire logic                  sec_pulse,     // one per second
	input wire logic                  day_carry, // hour wrap pulse
	input wire rctwa_pkg::rctwa_cal_t cal        // calendar
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// ----
	// decode
	// ----
	wire rd = reg_rd && !reg_wr;
	wire cy = day_carry && !reg_wr;
	wire [3:0] u = cal.year[3:0];
	// bcd year divisible by four
	wire leap = cal.year[4] ? (u == 4'h2 || u == 4'h6) :
		(u == 4'h0 || u == 4'h4 || u == 4'h8);
	a_day_readback: assert property (rd && reg_addr == 4'h4 |=>
		reg_rdata == {2'h0, $past(cal.day)}) else $error("day read bad");
	a_month_readback: assert property (rd && reg_addr == 4'h5 |=>
		reg_rdata == {$past(cal.cent), 2'h0, $past(cal.month)})
		else $error("month read bad");
	a_year_readback: assert property (rd && reg_addr == 4'h6 |=>
		reg_rdata == $past(cal.year)) else $error("year read bad");
	a_trim_guard: assert property (rd && reg_addr == 4'h7 |=>
		!reg_rdata[7]) else $error("trim guard bit reads one");
	a_wmin_top: assert property (rd && reg_addr == 4'h8 |=>
		!reg_rdata[7]) else $error("alarm minute bit 7 set");
	a_whour_top: assert property (rd && reg_addr == 4'h9 |=>
		reg_rdata[7:6] == 2'h0) else $error("alarm hour top bits set");
	a_day_write: assert property (reg_wr && reg_addr == 4'h4 |=>
		cal.day == $past(reg_wdata[5:0])) else $error("day write lost");
	a_long_wrap: assert property (cy && cal.day == 6'h31 |=>
		cal.day == 6'h01 && cal.month != $past(cal.month))
		else $error("day 31 did not wrap");
	a_feb_end: assert property (cy && cal.month == 5'h02 &&
		cal.day == 6'h28 |=> cal.day == (leap ? 6'h29 : 6'h01))
		else $error("february end wrong");
	a_cent_flip: assert property (cy && cal.year == 8'h99 &&
		cal.month == 5'h12 && cal.day == 6'h31 |=> cal.year == 8'h00
		&& cal.cent != $past(cal.cent)) else $error("century not flipped");
	a_halt_sticky: assert property (osc_halt_flag && !osc_halt_clr |=>
		osc_halt_flag) else $error("halt flag dropped by itself");
	a_sec_single: assert property (sec_pulse |=> !sec_pulse)
		else $error("second tick longer than one cycle");
	cover property (cy && cal.month == 5'h12);
	cover property (cy && cal.month == 5'h02);
	cover property (reg_wr && reg_addr == 4'h7);
endmodule // rctwa_chk
bind rctwa_core rctwa_chk rctwa_chk_inst (.clk, .resetn, .reg_wr, .reg_rd,
	.reg_addr, .reg_wdata, .reg_rdata, .day_carry, .cal, .osc_halt_clr,
	.osc_halt_flag, .sec_pulse);

// ---- rctwa_host.sv ----
// host model driving the register port, with its expected-read queue
`timescale 1ns/10ps
module rctwa_host (
	input  wire logic clk,          // system clock
	output logic      reg_wr,       // write strobe
	output logic      reg_rd,       // read strobe
	output logic [3:0] reg_addr,    // register addr
	output logic [7:0] reg_wdata,   // write data
	output logic      day_carry,    // hour wrap pulse
	output logic      osc_halt_clr  // clear halt
);
	logic [7:0] exp_q[$];
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		day_carry = 1'b0;
		osc_halt_clr = 1'b0;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		// a released bus must not look like the last byte
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(negedge clk);
	endtask
	task automatic pulse(input logic carry);
		@(negedge clk);
		day_carry = carry;
		osc_halt_clr = !carry;
		@(negedge clk);
		day_carry = 1'b0;
		osc_halt_clr = 1'b0;
	endtask
endmodule // rctwa_host

// ---- tb.sv ----
// self-checking bench for the calendar, trim and alarm core
`timescale 1ns/10ps
module tb;
	logic clk = 1'b0;
	logic resetn = 1'b1;
	logic sec_seen = 1'b0;
	logic xtal_clk = 1'b0;
	logic xen = 1'b1;
	logic reg_wr, reg_rd, day_carry, osc_halt_clr, sec_pulse, osc_halt_flag;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, v, t;
	logic [47:0] c;
	rctwa_pkg::rctwa_cal_t cal;
	rctwa_pkg::rctwa_alarm_t walarm;
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;
	logic p1 = 1'b0;
	logic p2 = 1'b0;
	localparam logic [7:0] MASK [6] = '{8'h3f, 8'h9f, 8'hff, 8'h7f,
		8'h7f, 8'h3f};
	// day, month, year written, then expected after one carry
	localparam logic [47:0] CAL [7] = '{48'h310123010223,
		48'h300423010523, 48'h280201010301, 48'h280204290204,
		48'h290200010300, 48'h311299018100, 48'h319299010100};
	always #5 clk = ~clk;
	initial begin
		#3.7;
		forever #80 if (xen) xtal_clk = ~xtal_clk;
	end
	rctwa_core #(.HALT_CYCLES(64)) rctwa_core_inst (.clk, .resetn,
		.xtal_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.day_carry, .osc_halt_clr, .sec_pulse, .osc_halt_flag, .cal,
		.walarm);
	rctwa_host rctwa_host_inst (.clk, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .day_carry, .osc_halt_clr);
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wait_flag(input logic f);
		for (int i = 0; i < 500 && osc_halt_flag !== f; i++)
			@(negedge clk);
	endtask
	always @(posedge clk) begin
		p1 <= reg_rd;
		p2 <= p1;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			print_verdict();
		end
	end
	always @(negedge clk) if (p2) begin
		chk(reg_rdata, rctwa_host_inst.exp_q.pop_front());
	end
	// the run is far shorter than one crystal second: no tick may show
	always @(negedge clk) if (sec_pulse) sec_seen <= 1'b1;
	initial begin
		void'($urandom(32'h1fbd));
		// a true falling edge, so both domains reset asynchronously
		#1 resetn = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		repeat (3) @(negedge clk);
		rctwa_host_inst.rd(4'h7, 8'h00);
		chk({7'h0, osc_halt_flag}, 8'h01);
		rctwa_host_inst.pulse(1'b0);
		wait_flag(1'b0);
		chk({7'h0, osc_halt_flag}, 8'h00);
		repeat (100) @(negedge clk);
		for (int i = 0; i < 6; i++) begin
			v = 8'($urandom);
			if (i == 3) v[7] = 1'b0;
			if (i == 3) t = v;
			rctwa_host_inst.wr(4'(4 + i), v);
			rctwa_host_inst.rd(4'(4 + i), v & MASK[i]);
		end
		chk({2'h0, walarm.hour}, v & MASK[5]);
		rctwa_host_inst.wr(4'hf, 8'hff);
		rctwa_host_inst.rd(4'hf, 8'h00);
		rctwa_host_inst.rd(4'h2, 8'h00);
		// guard bit set: write must be ignored
		repeat (100) @(negedge clk);
		rctwa_host_inst.wr(4'h7, ~t);
		rctwa_host_inst.rd(4'h7, t);
		for (int i = 0; i < 7; i++) begin
			c = CAL[i];
			rctwa_host_inst.wr(4'h6, c[31:24]);
			rctwa_host_inst.wr(4'h5, c[39:32]);
			rctwa_host_inst.wr(4'h4, c[47:40]);
			rctwa_host_inst.pulse(1'b1);
			rctwa_host_inst.rd(4'h4, c[23:16]);
			rctwa_host_inst.rd(4'h5, c[15:8]);
			rctwa_host_inst.rd(4'h6, c[7:0]);
		end
		chk({cal.cent, 2'h0, cal.month}, c[15:8]);
		chk(cal.year, c[7:0]);
		// a known trim, so the clear on halt is visible; let it cross first
		rctwa_host_inst.wr(4'h7, 8'h07);
		repeat (100) @(negedge clk);
		xen = 1'b0;
		wait_flag(1'b1);
		xen = 1'b1;
		repeat (50) @(negedge clk);
		chk({7'h0, osc_halt_flag}, 8'h01);
		rctwa_host_inst.rd(4'h7, 8'h00);
		repeat (5) @(negedge clk);
		chk({7'h0, sec_seen}, 8'h00);
		print_verdict();
	end
endmodule // tb
